// ### design/fcd_defs.vh
// Constants for the flash command host controller
`ifndef FCD_DEFS_VH
`define FCD_DEFS_VH
`define FCD_ADDR_W 23
`define FCD_DATA_W 16
`define FCD_SECTOR_LSB 16
`define FCD_UNLOCK1_ADDR 23'h000555
`define FCD_UNLOCK2_ADDR 23'h0002aa
`define FCD_UNLOCK1_DATA 16'h00aa
`define FCD_UNLOCK2_DATA 16'h0055
`define FCD_CMD_RESET 16'h00f0
`define FCD_CMD_AUTOSEL 16'h0090
`define FCD_CMD_PROGRAM 16'h00a0
`define FCD_CMD_WRBUF 16'h0025
`define FCD_CMD_BUFPROG 16'h0029
`define FCD_CMD_ERASE 16'h0080
`define FCD_CMD_CHIPER 16'h0010
`define FCD_CMD_SECTER 16'h0030
`define FCD_CMD_SUSPEND 16'h00b0
`define FCD_CMD_RESUME 16'h0030
`define FCD_CMD_SECENTRY 16'h0088
`define FCD_CMD_EXITDATA 16'h0000
`define FCD_CMD_CFI 16'h0098
`define FCD_CFI_ADDR 23'h000055
// Operation codes on the user port
`define FCD_OP_READ 4'h0
`define FCD_OP_RESET 4'h1
`define FCD_OP_AUTOSEL 4'h2
`define FCD_OP_PROGRAM 4'h3
`define FCD_OP_BUFFER 4'h4
`define FCD_OP_CHIPER 4'h5
`define FCD_OP_SECTER 4'h6
`define FCD_OP_SUSPEND 4'h7
`define FCD_OP_RESUME 4'h8
`define FCD_OP_SECENTRY 4'h9
`define FCD_OP_SECEXIT 4'ha
`define FCD_OP_ABORTRST 4'hb
`define FCD_OP_CFI 4'hc
// Strobe timing in cycles of 8 ns
`define FCD_SETUP_CYC 4'h2
`define FCD_PULSE_CYC 4'h6
`define FCD_HOLD_CYC 4'h2
`define FCD_READ_CYC 4'ha
`endif

// ### design/fcd_bus_cycle.v
// One asynchronous flash bus cycle: a write or a read, strobes timed by counters
`include "fcd_defs.vh"
module fcd_bus_cycle (
  input wire core_clk,
  input wire resetn,
  input wire cycStart,
  input wire cycWrite,
  input wire [`FCD_ADDR_W-1:0] cycAddr,
  input wire [`FCD_DATA_W-1:0] cycData,
  output wire cycDone,
  output reg [`FCD_DATA_W-1:0] cycRdData_q,
  output reg [`FCD_ADDR_W-1:0] flAddr_q,
  output reg [`FCD_DATA_W-1:0] flDqOut_q,
  output reg flDqOe_q,
  input wire [`FCD_DATA_W-1:0] flDqIn,
  output reg flCeN_q,
  output reg flWeN_q,
  output reg flOeN_q
);
  localparam S_IDLE = 4'b0001;
  localparam S_SETUP = 4'b0010;
  localparam S_PULSE = 4'b0100;
  localparam S_HOLD = 4'b1000;
  reg [3:0] state_q;
  reg [3:0] cnt_q;
  reg isWrite_q;
  reg doneP_q;
  reg [`FCD_DATA_W-1:0] dqS1_q;
  reg [`FCD_DATA_W-1:0] dqS2_q;
  assign cycDone = doneP_q;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= S_IDLE;
      cnt_q <= 4'h0;
      isWrite_q <= 1'b0;
      doneP_q <= 1'b0;
      cycRdData_q <= {`FCD_DATA_W{1'b0}};
      flAddr_q <= {`FCD_ADDR_W{1'b0}};
      flDqOut_q <= {`FCD_DATA_W{1'b0}};
      flDqOe_q <= 1'b0;
      flCeN_q <= 1'b1;
      flWeN_q <= 1'b1;
      flOeN_q <= 1'b1;
      dqS1_q <= {`FCD_DATA_W{1'b0}};
      dqS2_q <= {`FCD_DATA_W{1'b0}};
    end else begin
      dqS1_q <= flDqIn;
      dqS2_q <= dqS1_q;
      doneP_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (cycStart) begin
            // Address settles before either strobe falls
            flAddr_q <= cycAddr;
            flDqOut_q <= cycData;
            flDqOe_q <= cycWrite;
            isWrite_q <= cycWrite;
            flCeN_q <= 1'b0;
            cnt_q <= `FCD_SETUP_CYC;
            state_q <= S_SETUP;
          end
        end
        S_SETUP: begin
          if (cnt_q == 4'h1) begin
            // WE falls after CE, so the device latches address here
            flWeN_q <= ~isWrite_q;
            flOeN_q <= isWrite_q;
            cnt_q <= isWrite_q ? `FCD_PULSE_CYC : `FCD_READ_CYC;
            state_q <= S_PULSE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        S_PULSE: begin
          if (cnt_q == 4'h1) begin
            // WE rises first while data still held, data latched here
            flWeN_q <= 1'b1;
            flOeN_q <= 1'b1;
            // Two extra cycles of access time cover the synchroniser
            if (!isWrite_q) cycRdData_q <= dqS2_q;
            cnt_q <= `FCD_HOLD_CYC;
            state_q <= S_HOLD;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        S_HOLD: begin
          if (cnt_q == 4'h1) begin
            flCeN_q <= 1'b1;
            flDqOe_q <= 1'b0;
            doneP_q <= 1'b1;
            state_q <= S_IDLE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule

// ### design/fcd_host_ctrl.v
// Host controller that issues flash command sequences over the parallel bus
`include "fcd_defs.vh"
module fcd_host_ctrl (
  input wire core_clk,
  input wire resetn,
  input wire opValid,
  output wire opReady,
  input wire [3:0] opCode,
  input wire [`FCD_ADDR_W-1:0] opAddr,
  input wire [`FCD_DATA_W-1:0] opData,
  input wire [5:0] opCount,
  output reg opDone_q,
  output reg [`FCD_DATA_W-1:0] rdData_q,
  input wire loadValid,
  output wire loadReady,
  input wire [`FCD_DATA_W-1:0] loadData,
  output wire [`FCD_ADDR_W-1:0] flAddr,
  output wire [`FCD_DATA_W-1:0] flDqOut,
  output wire flDqOe,
  input wire [`FCD_DATA_W-1:0] flDqIn,
  output wire flCeN,
  output wire flWeN,
  output wire flOeN
);
  localparam S_IDLE = 4'b0001;
  localparam S_ISSUE = 4'b0010;
  localparam S_WAIT = 4'b0100;
  localparam S_STALL = 4'b1000;
  localparam [`FCD_ADDR_W-1:0] ZADDR = {`FCD_ADDR_W{1'b0}};
  reg [3:0] state_q;
  reg [`FCD_DATA_W-1:0] loadWord_q;
  reg [3:0] op_q;
  reg [`FCD_ADDR_W-1:0] addr_q;
  reg [`FCD_DATA_W-1:0] data_q;
  reg [5:0] count_q;
  reg [5:0] loadIdx_q;
  reg [2:0] step_q;
  reg stepWrite;
  reg [`FCD_ADDR_W-1:0] stepAddr;
  reg [`FCD_DATA_W-1:0] stepData;
  reg lastStep;
  reg needLoad;
  wire cycDone;
  wire [`FCD_DATA_W-1:0] cycRdData;
  wire [`FCD_ADDR_W-1:0] sectorBase;
  wire [`FCD_ADDR_W-1:0] pageAddr;
  wire stepEnd;
  // Only the sector field survives, low bits forced to zero
  assign sectorBase = {addr_q[`FCD_ADDR_W-1:`FCD_SECTOR_LSB],
                       {`FCD_SECTOR_LSB{1'b0}}};
  // Loads advance within the page that the first address opened
  assign pageAddr = {addr_q[`FCD_ADDR_W-1:5], addr_q[4:0] + loadIdx_q[4:0]};
  assign opReady = (state_q == S_IDLE);
  // Issuing waits on the user load stream; the device has no stall of its own
  // Done is a one-cycle pulse, so a stalled step ends in its own state
  assign stepEnd = ((state_q == S_WAIT) && cycDone) || (state_q == S_STALL);
  assign loadReady = stepEnd && needLoad;
  always @* begin
    stepWrite = 1'b1;
    stepAddr = `FCD_UNLOCK1_ADDR;
    stepData = `FCD_UNLOCK1_DATA;
    lastStep = 1'b0;
    needLoad = 1'b0;
    if (step_q == 3'h1) begin
      stepAddr = `FCD_UNLOCK2_ADDR;
      stepData = `FCD_UNLOCK2_DATA;
    end
    case (op_q)
      `FCD_OP_READ: begin
        stepWrite = 1'b0;
        stepAddr = addr_q;
        lastStep = 1'b1;
      end
      `FCD_OP_RESET: begin
        stepAddr = ZADDR;
        stepData = `FCD_CMD_RESET;
        lastStep = 1'b1;
      end
      `FCD_OP_SUSPEND: begin
        stepAddr = ZADDR;
        stepData = `FCD_CMD_SUSPEND;
        lastStep = 1'b1;
      end
      `FCD_OP_RESUME: begin
        stepAddr = ZADDR;
        stepData = `FCD_CMD_RESUME;
        lastStep = 1'b1;
      end
      `FCD_OP_CFI: begin
        stepAddr = `FCD_CFI_ADDR;
        stepData = `FCD_CMD_CFI;
        lastStep = 1'b1;
      end
      `FCD_OP_SECENTRY: begin
        if (step_q == 3'h2) begin
          stepData = `FCD_CMD_SECENTRY;
          lastStep = 1'b1;
        end
      end
      `FCD_OP_ABORTRST: begin
        if (step_q == 3'h2) begin
          stepData = `FCD_CMD_RESET;
          lastStep = 1'b1;
        end
      end
      `FCD_OP_SECEXIT: begin
        if (step_q == 3'h2) stepData = `FCD_CMD_AUTOSEL;
        if (step_q == 3'h3) begin
          stepAddr = ZADDR;
          stepData = `FCD_CMD_EXITDATA;
          lastStep = 1'b1;
        end
      end
      `FCD_OP_AUTOSEL: begin
        if (step_q == 3'h2) stepData = `FCD_CMD_AUTOSEL;
        if (step_q == 3'h3) begin
          // Read at sector base plus the low offset given by the user
          stepWrite = 1'b0;
          stepAddr = sectorBase | {{(`FCD_ADDR_W-8){1'b0}}, addr_q[7:0]};
          lastStep = 1'b1;
        end
      end
      `FCD_OP_PROGRAM: begin
        if (step_q == 3'h2) stepData = `FCD_CMD_PROGRAM;
        if (step_q == 3'h3) begin
          stepAddr = addr_q;
          stepData = data_q;
          lastStep = 1'b1;
        end
      end
      `FCD_OP_CHIPER, `FCD_OP_SECTER: begin
        if (step_q == 3'h2) stepData = `FCD_CMD_ERASE;
        if (step_q == 3'h4) begin
          stepAddr = `FCD_UNLOCK2_ADDR;
          stepData = `FCD_UNLOCK2_DATA;
        end
        if (step_q == 3'h5) begin
          lastStep = 1'b1;
          if (op_q == `FCD_OP_CHIPER) begin
            stepData = `FCD_CMD_CHIPER;
          end else begin
            stepAddr = sectorBase;
            stepData = `FCD_CMD_SECTER;
          end
        end
      end
      `FCD_OP_BUFFER: begin
        if (step_q == 3'h2) begin
          stepAddr = sectorBase;
          stepData = `FCD_CMD_WRBUF;
        end
        if (step_q == 3'h3) begin
          stepAddr = sectorBase;
          stepData = {{(`FCD_DATA_W-6){1'b0}}, count_q};
          needLoad = 1'b1;
        end
        if (step_q == 3'h4) begin
          stepAddr = pageAddr;
          stepData = loadWord_q;
          needLoad = (loadIdx_q != count_q);
        end
        if (step_q == 3'h5) begin
          stepAddr = sectorBase;
          stepData = `FCD_CMD_BUFPROG;
          lastStep = 1'b1;
        end
      end
      default: lastStep = 1'b1;
    endcase
  end
  fcd_bus_cycle u_cycle (
    .core_clk(core_clk),
    .resetn(resetn),
    .cycStart(state_q == S_ISSUE),
    .cycWrite(stepWrite),
    .cycAddr(stepAddr),
    .cycData(stepData),
    .cycDone(cycDone),
    .cycRdData_q(cycRdData),
    .flAddr_q(flAddr),
    .flDqOut_q(flDqOut),
    .flDqOe_q(flDqOe),
    .flDqIn(flDqIn),
    .flCeN_q(flCeN),
    .flWeN_q(flWeN),
    .flOeN_q(flOeN)
  );
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= S_IDLE;
      op_q <= `FCD_OP_READ;
      addr_q <= ZADDR;
      data_q <= {`FCD_DATA_W{1'b0}};
      count_q <= 6'h00;
      loadIdx_q <= 6'h00;
      step_q <= 3'h0;
      opDone_q <= 1'b0;
      rdData_q <= {`FCD_DATA_W{1'b0}};
      loadWord_q <= {`FCD_DATA_W{1'b0}};
    end else begin
      opDone_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (opValid) begin
            op_q <= opCode;
            addr_q <= opAddr;
            data_q <= opData;
            // Buffer holds 32 words, count cut to its low five bits to match
            count_q <= {1'b0, opCount[4:0]};
            loadIdx_q <= 6'h00;
            step_q <= 3'h0;
            state_q <= S_ISSUE;
          end
        end
        S_ISSUE: state_q <= S_WAIT;
        S_WAIT, S_STALL: begin
          if (stepEnd) begin
            if (lastStep) begin
              if (!stepWrite) rdData_q <= cycRdData;
              opDone_q <= 1'b1;
              state_q <= S_IDLE;
            end else if (needLoad && !loadValid) begin
              // Bus idles with CE high until the loader catches up
              state_q <= S_STALL;
            end else begin
              // Word held here, the loader may move on at once
              if (needLoad) loadWord_q <= loadData;
              if (op_q == `FCD_OP_BUFFER && step_q == 3'h4) begin
                loadIdx_q <= loadIdx_q + 6'h01;
                if (!needLoad) step_q <= 3'h5;
              end else begin
                step_q <= step_q + 3'h1;
              end
              state_q <= S_ISSUE;
            end
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule

// ### dv/fcd_host_ctrl_monitor.sv
// Port checker for the flash host controller
`include "fcd_defs.vh"
module fcd_host_ctrl_monitor (
  input wire core_clk,
  input wire resetn,
  input wire opValid,
  input wire opReady,
  input wire opDone_q,
  input wire [`FCD_ADDR_W-1:0] flAddr,
  input wire [`FCD_DATA_W-1:0] flDqOut,
  input wire flDqOe,
  input wire flCeN,
  input wire flWeN,
  input wire flOeN
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  we_under_ce_a: assert property (!flWeN |-> !flCeN)
    else $error("write strobe outside chip enable");
  addr_hold_a: assert property (!flWeN |=> $stable(flAddr))
    else $error("address moved under write strobe");
  data_hold_a: assert property (!flWeN |-> flDqOe && $stable(flDqOut))
    else $error("write data not driven steadily");
  we_width_a: assert property ($fell(flWeN) |-> (!flWeN)[*6] ##1 flWeN)
    else $error("write strobe width wrong");
  read_excl_a: assert property (!flOeN |-> flWeN && !flDqOe && !flCeN)
    else $error("read overlaps drive or write");
  read_width_a: assert property ($fell(flOeN) |-> ##9 !flOeN ##1 flOeN)
    else $error("read strobe width wrong");
  done_once_a: assert property (opDone_q |=> !opDone_q)
    else $error("done held too long");
  ready_back_a: assert property (opDone_q |-> opReady)
    else $error("not ready after done");
  take_busy_a: assert property (opValid && opReady |=> !opReady)
    else $error("still ready after accept");
endmodule
bind fcd_host_ctrl fcd_host_ctrl_monitor mon (.core_clk(core_clk), .resetn(resetn),
  .opValid(opValid), .opReady(opReady), .opDone_q(opDone_q), .flAddr(flAddr),
  .flDqOut(flDqOut), .flDqOe(flDqOe), .flCeN(flCeN), .flWeN(flWeN), .flOeN(flOeN));

// ### dv/fcd_flash_model.sv
// Behavioural flash device that logs command writes and serves reads
module fcd_flash_model (
  input wire [22:0] flAddr,
  input wire [15:0] flDqOut,
  input wire flCeN,
  input wire flWeN,
  input wire flOeN,
  output logic [15:0] flDqIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [int];
  logic [22:0] wa[$];
  logic [15:0] wd[$];
  logic [22:0] la;
  int n;
  wire strobeN = flWeN | flCeN;
  function automatic logic [15:0] rd(int a);
    return mem.exists(a) ? mem[a] : ~a[15:0];
  endfunction
  always @(negedge strobeN) la = flAddr;
  always @(posedge strobeN) begin
    wa.push_back(la);
    wd.push_back(flDqOut);
    n = wd.size();
    if (n > 3 && wd[n-4] == 'haa && wd[n-2] == 'ha0 && wa[n-2] == 'h555)
      mem[la] = flDqOut;
  end
  // Released bus shows the inverse, so a stale sample cannot pass
  always @* flDqIn = (!flOeN && !flCeN) ? rd(flAddr) : ~rd(flAddr);
endmodule

// ### dv/fcd_host_ctrl_tb_top.sv
// Self-checking bench for the flash host controller
`include "fcd_defs.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module fcd_host_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, resetn = 0, opValid = 0, loadValid = 0;
  logic [3:0] opCode = 0;
  logic [22:0] opAddr = 0, a, b, s;
  logic [15:0] opData = 0, loadData = 0, d;
  logic [5:0] opCount = 0, c;
  wire opReady, opDone_q, loadReady, flDqOe, flCeN, flWeN, flOeN;
  wire [15:0] rdData_q, flDqOut, flDqIn;
  wire [22:0] flAddr;
  int fails = 0, tests_run = 0, cyc = 0, seed = 50;
  logic [22:0] eA[$];
  logic [15:0] eD[$], ld[$];
  fcd_host_ctrl dut (.core_clk, .resetn, .opValid, .opReady, .opCode, .opAddr,
    .opData, .opCount, .opDone_q, .rdData_q, .loadValid, .loadReady, .loadData,
    .flAddr, .flDqOut, .flDqOe, .flDqIn, .flCeN, .flWeN, .flOeN);
  fcd_flash_model dev (.flAddr, .flDqOut, .flCeN, .flWeN, .flOeN, .flDqIn);
  initial forever #4 core_clk = ~core_clk;
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      wrap_up();
    end
  end
  // Loader stalls at random so the controller must wait between words
  bit took;
  always @(posedge core_clk) took <= loadValid && loadReady;
  always @(negedge core_clk) begin
    if (took) void'(ld.pop_front());
    // A word once offered stays up until it is taken
    if (!loadValid || took) begin
      loadValid <= ld.size() > 0 && ($random(seed) & 3) != 0;
      if (ld.size() > 0) loadData <= ld[0];
    end
  end
  task automatic ex(input logic [22:0] x, input logic [15:0] y);
    eA.push_back(x);
    eD.push_back(y);
  endtask
  task automatic unl;
    ex('h555, 'haa);
    ex('h2aa, 'h55);
  endtask
  task automatic run(input logic [3:0] o, input logic [22:0] x, input logic [15:0] y,
      input logic [5:0] z);
    int k;
    @(negedge core_clk);
    opCode = o;
    opAddr = x;
    opData = y;
    opCount = z;
    opValid = 1;
    @(negedge core_clk);
    opValid = 0;
    k = 0;
    while (opDone_q !== 1 && k++ < 3000) @(negedge core_clk);
    `CHK("done", 1'b1, opDone_q)
    `CHK("cycles", eA.size(), dev.wa.size())
    foreach (eA[i]) begin
      `CHK("addr", eA[i], dev.wa[i])
      `CHK("data", eD[i], dev.wd[i])
    end
    $display("op %h done", o);
    eA.delete();
    eD.delete();
    dev.wa.delete();
    dev.wd.delete();
  endtask
  initial begin
    repeat (10) @(negedge core_clk);
    resetn = 1;
    dev.wa.delete();
    dev.wd.delete();
    for (int t = 0; t < 4; t++) begin
      a = $random(seed) | 'h8000;
      d = $random(seed);
      s = {a[22:16], 16'h0};
      unl;
      ex('h555, 'ha0);
      ex(a, d);
      run(`FCD_OP_PROGRAM, a, d, 0);
      run(`FCD_OP_READ, a, 0, 0);
      `CHK("read", d, rdData_q)
      unl;
      ex('h555, 'h90);
      run(`FCD_OP_AUTOSEL, a, 0, 0);
      `CHK("ident", ~{a[15:8] & 8'h0, a[7:0]}, rdData_q)
      unl;
      ex('h555, 'h80);
      unl;
      ex(s, 'h30);
      run(`FCD_OP_SECTER, a, 0, 0);
      c = $random(seed) & 7;
      b = a | 'h1c;
      unl;
      ex(s, 'h25);
      ex(s, c);
      for (int i = 0; i <= c; i++) begin
        d = $random(seed);
        ld.push_back(d);
        ex({b[22:5], 5'(b[4:0] + i)}, d);
      end
      ex(s, 'h29);
      run(`FCD_OP_BUFFER, b, 0, c);
    end
    unl;
    ex('h555, 'h80);
    unl;
    ex('h555, 'h10);
    run(`FCD_OP_CHIPER, 0, 0, 0);
    unl;
    ex('h555, 'h88);
    run(`FCD_OP_SECENTRY, 0, 0, 0);
    unl;
    ex('h555, 'h90);
    ex(0, 0);
    run(`FCD_OP_SECEXIT, 0, 0, 0);
    unl;
    ex('h555, 'hf0);
    run(`FCD_OP_ABORTRST, 0, 0, 0);
    ex(0, 'hf0);
    run(`FCD_OP_RESET, 0, 0, 0);
    ex(0, 'hb0);
    run(`FCD_OP_SUSPEND, 0, 0, 0);
    ex(0, 'h30);
    run(`FCD_OP_RESUME, 0, 0, 0);
    ex('h55, 'h98);
    run(`FCD_OP_CFI, 0, 0, 0);
    ex('h555, 'haa);
    run(4'hf, 0, 0, 0);
    wrap_up();
  end
endmodule
